//--- src/tmc_ctrl.sv
// Functional notes
// RULE_01 - Rate select in configuration bits zero to two
// RULE_02 - Codes 3..7 give 1..16 conversions per second
// RULE_03 - One three-zone conversion lasts about 60 ms
// RULE_04 - Configuration bit six: 0 run, 1 standby
// RULE_05 - Run mode converts repeatedly at programmed rate
// RULE_06 - Standby stops conversions, powers measurement down
// RULE_07 - Register access works in both modes
// RULE_08 - One-shot write in standby runs one cycle
// RULE_09 - After one-shot, back to standby, results readable
// RULE_10 - Ideality registers reset to 12h
// RULE_11 - Low six ideality bits drive diode correction
// RULE_12 - Status bit seven high while converting
// RULE_13 - Legacy and extended results update together
// RULE_14 - One-shot write triggers, stores nothing
//
// Top of the temperature monitor control: register file, result capture and
// conversion scheduling. Assumes the register port is driven by the serial
// slave already decoded to byte accesses, synchronous to mclk_i.
`timescale 1ns/1ns
module tmc_ctrl import tmc_pkg::*; #(
  parameter int unsigned CONV_CYC   = CONV_CYCLES,
  parameter int unsigned PERIOD_CYC = PERIOD_BASE_CYC
) (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  // Register access port
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  output logic      [7:0]         reg_rdata_o,
  // Measurement front end
  input  wire logic [TEMP_W-1:0]  int_temp_i,
  input  wire logic [TEMP_W-1:0]  rem1_temp_i,
  input  wire logic [TEMP_W-1:0]  rem2_temp_i,
  output logic                    meas_enable_o,
  output logic                    conv_start_o,
  output logic                    standby_o,
  output logic      [IDEAL_W-1:0] ideal_code1_o,
  output logic      [IDEAL_W-1:0] ideal_code2_o
);

  tmc_sched_if sif ();

  logic [7:0]        cfg;            // Configuration register
  logic [7:0]        next_cfg;
  logic [7:0]        ideal [2];      // Ideality registers, remote 1 and 2
  logic [7:0]        next_ideal [2];
  logic [TEMP_W-1:0] leg [3];        // Legacy results: internal, remote 1, 2
  logic [TEMP_W-1:0] next_leg [3];
  logic [TEMP_W-1:0] ext [2];        // Extended results, remote 1 and 2
  logic [TEMP_W-1:0] next_ext [2];
  logic [TEMP_W-1:0] ext_calc [2];   // Extended form of fresh samples
  logic [TEMP_W-1:0] raw [3];        // Front end samples
  logic [1:0]        fault;          // Diode fault flags
  logic [1:0]        next_fault;
  logic [7:0]        rdata;          // Read mux output
  logic [7:0]        status;         // Status byte
  logic              one_shot_p;     // Registered one-shot trigger
  logic              next_one_shot_p;

  assign raw[0] = int_temp_i;
  assign raw[1] = rem1_temp_i;
  assign raw[2] = rem2_temp_i;

  // Controller side of the scheduler link
  assign sif.rate_sel = cfg[CFG_RATE_MSB:CFG_RATE_LSB]; // RULE_01
  assign sif.standby  = cfg[CFG_STANDBY_BIT];           // RULE_04
  assign sif.one_shot = one_shot_p;

  tmc_conv_sched #(
    .CONV_CYC   (CONV_CYC),
    .PERIOD_CYC (PERIOD_CYC)
  ) u_sched (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .sif     (sif)
  );

  // Extended format per remote: subtract 64 degrees, clamp, keep fault code
  for (genvar g = 0; g < 2; g++) begin : g_ext
    logic signed [11:0] diff;
    assign diff = $signed({raw[g+1][TEMP_W-1], raw[g+1]}) - EXT_OFFSET;
    always_comb begin
      if (raw[g+1] == TEMP_FAULT) begin
        ext_calc[g] = TEMP_FAULT;
      end else if (diff < EXT_FLOOR) begin
        ext_calc[g] = TEMP_EXT_MIN;
      end else begin
        ext_calc[g] = diff[TEMP_W-1:0];
      end
    end
  end

  assign status = {sif.busy, 5'h00, fault}; // RULE_12

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata = 8'h00;
    if (reg_addr_i == ADDR_INT_HI) begin
      rdata = leg[0][10:3];
    end else if (reg_addr_i == ADDR_INT_LO) begin
      rdata = {leg[0][2:0], 5'h00};
    end else if (reg_addr_i == ADDR_REM1_HI) begin
      rdata = leg[1][10:3];
    end else if (reg_addr_i == ADDR_REM1_LO) begin
      rdata = {leg[1][2:0], 5'h00};
    end else if (reg_addr_i == ADDR_REM2_HI) begin
      rdata = leg[2][10:3];
    end else if (reg_addr_i == ADDR_REM2_LO) begin
      rdata = {leg[2][2:0], 5'h00};
    end else if (reg_addr_i == ADDR_EXT1_HI) begin
      rdata = ext[0][10:3];
    end else if (reg_addr_i == ADDR_EXT1_LO) begin
      rdata = {ext[0][2:0], 5'h00};
    end else if (reg_addr_i == ADDR_EXT2_HI) begin
      rdata = ext[1][10:3];
    end else if (reg_addr_i == ADDR_EXT2_LO) begin
      rdata = {ext[1][2:0], 5'h00};
    end else if (reg_addr_i == ADDR_STATUS) begin
      rdata = status;
    end else if (reg_addr_i == ADDR_CFG_RD) begin
      rdata = cfg;
    end else if (reg_addr_i == ADDR_IDEAL1) begin
      rdata = ideal[0];
    end else if (reg_addr_i == ADDR_IDEAL2) begin
      rdata = ideal[1];
    end
  end

  // Next values for registers; access never depends on mode
  always_comb begin
    next_cfg        = cfg;
    next_ideal      = ideal;
    next_leg        = leg;
    next_ext        = ext;
    next_fault      = fault;
    next_one_shot_p = 1'b0;
    if (reg_wr_i) begin // RULE_07
      if (reg_addr_i == ADDR_CFG_WR) begin
        next_cfg = reg_wdata_i;
      end else if (reg_addr_i == ADDR_ONE_SHOT) begin
        // Data byte ignored; only the strobe matters
        next_one_shot_p = 1'b1; // RULE_14
      end else if (reg_addr_i == ADDR_IDEAL1) begin
        next_ideal[0] = reg_wdata_i;
      end else if (reg_addr_i == ADDR_IDEAL2) begin
        next_ideal[1] = reg_wdata_i;
      end
    end
    // All result formats refresh in the same cycle
    if (sif.conv_done) begin // RULE_13
      next_leg   = raw;
      next_ext   = ext_calc;
      next_fault = {raw[2] == TEMP_FAULT, raw[1] == TEMP_FAULT};
    end
  end

  // Register file and output flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg           <= CFG_RESET;
      ideal         <= '{IDEAL_RESET, IDEAL_RESET}; // RULE_10
      leg           <= '{'0, '0, '0};
      ext           <= '{'0, '0};
      fault         <= '0;
      one_shot_p    <= 1'b0;
      reg_rdata_o   <= 8'h00;
      meas_enable_o <= 1'b0;
      conv_start_o  <= 1'b0;
      standby_o     <= 1'b1;
      ideal_code1_o <= IDEAL_RESET[IDEAL_W-1:0];
      ideal_code2_o <= IDEAL_RESET[IDEAL_W-1:0];
    end else begin
      cfg           <= next_cfg;
      ideal         <= next_ideal;
      leg           <= next_leg;
      ext           <= next_ext;
      fault         <= next_fault;
      one_shot_p    <= next_one_shot_p;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata;
      end
      // Front end powered only while a cycle runs
      meas_enable_o <= sif.busy; // RULE_06
      conv_start_o  <= sif.conv_start;
      standby_o     <= cfg[CFG_STANDBY_BIT];
      // Upper ideality bits are ignored by the correction
      ideal_code1_o <= ideal[0][IDEAL_W-1:0]; // RULE_11
      ideal_code2_o <= ideal[1][IDEAL_W-1:0]; // RULE_11
    end
  end

  a_result_update: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_13
    sif.conv_done |=> (leg[1] == $past(rem1_temp_i)) && (ext[0] == $past(ext_calc[0])))
    else $error("results not updated together");
  a_one_shot_nostore: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_14
    reg_wr_i && reg_addr_i == ADDR_ONE_SHOT |=> $stable(cfg) && $stable(ideal[0]) && one_shot_p)
    else $error("one-shot write changed a register");
  a_busy_status: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_12
    reg_rd_i && reg_addr_i == ADDR_STATUS |=> reg_rdata_o[STATUS_BUSY_BIT] == $past(sif.busy))
    else $error("status busy bit wrong");
  a_ideal_apply: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_11
    reg_wr_i && reg_addr_i == ADDR_IDEAL1 |=> ##1 ideal_code1_o == $past(reg_wdata_i[IDEAL_W-1:0], 2))
    else $error("ideality code not applied");
  a_power_down: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_06
    sif.conv_done |=> !meas_enable_o)
    else $error("measurement left powered after conversion");

  // Configuration writes land in the rate field and, a cycle later, on the standby pin
  a_rate_field: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_01
    reg_wr_i && reg_addr_i == ADDR_CFG_WR |=> sif.rate_sel == $past(reg_wdata_i[CFG_RATE_MSB:CFG_RATE_LSB]))
    else $error("rate field not taken from low configuration bits");
  a_standby_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_04
    reg_wr_i && reg_addr_i == ADDR_CFG_WR |=> ##1 standby_o == $past(reg_wdata_i[CFG_STANDBY_BIT], 2))
    else $error("standby pin does not follow configuration bit");
  // Register writes are accepted whatever the power mode
  a_reg_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_07
    reg_wr_i && reg_addr_i == ADDR_IDEAL2 |=> ideal[1] == $past(reg_wdata_i))
    else $error("register write lost");

endmodule // tmc_ctrl

//--- src/tmc_pkg.sv
// Constants, register map and types for the temperature monitor control block.
// Assumes a single 125 MHz clock; all counts are derived from that rate.
package tmc_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ            = 125_000_000;       // System clock rate
  localparam int unsigned CONV_TIME_MS      = 60;                // Three-zone conversion time
  localparam int unsigned CONV_CYCLES       = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int unsigned BASE_RATE_HZ      = 1;                 // Slowest selectable rate
  localparam int unsigned PERIOD_BASE_CYC   = CLK_HZ / BASE_RATE_HZ;
  localparam int unsigned CNT_W             = 27;                // Holds one second of cycles

  // Register addresses (separate read and write addresses where they differ)
  localparam logic [7:0] ADDR_INT_HI        = 8'h00;
  localparam logic [7:0] ADDR_INT_LO        = 8'h23;
  localparam logic [7:0] ADDR_REM1_HI       = 8'h01;
  localparam logic [7:0] ADDR_REM1_LO       = 8'h10;
  localparam logic [7:0] ADDR_REM2_HI       = 8'hf8;
  localparam logic [7:0] ADDR_REM2_LO       = 8'hf9;
  localparam logic [7:0] ADDR_EXT1_HI       = 8'hfa;
  localparam logic [7:0] ADDR_EXT1_LO       = 8'hfb;
  localparam logic [7:0] ADDR_EXT2_HI       = 8'hfc;
  localparam logic [7:0] ADDR_EXT2_LO       = 8'hfd;
  localparam logic [7:0] ADDR_STATUS        = 8'h02;
  localparam logic [7:0] ADDR_CFG_RD        = 8'h03;
  localparam logic [7:0] ADDR_CFG_WR        = 8'h09;
  localparam logic [7:0] ADDR_ONE_SHOT      = 8'h0f;
  localparam logic [7:0] ADDR_IDEAL1        = 8'h27;
  localparam logic [7:0] ADDR_IDEAL2        = 8'h28;

  // Reset values and field positions
  localparam logic [7:0] CFG_RESET          = 8'h47;
  localparam logic [7:0] IDEAL_RESET        = 8'h12;
  localparam int unsigned CFG_STANDBY_BIT   = 6;
  localparam int unsigned CFG_RATE_LSB      = 0;
  localparam int unsigned CFG_RATE_MSB      = 2;
  localparam int unsigned STATUS_BUSY_BIT   = 7;
  localparam int unsigned IDEAL_W           = 6;                 // Significant ideality bits
  localparam logic [2:0] RATE_MIN_CODE      = 3'h3;              // 1 conversion per second

  // Temperature codes
  localparam int unsigned TEMP_W            = 11;
  localparam logic [10:0] TEMP_FAULT        = 11'h400;           // Diode fault marker
  localparam logic [10:0] TEMP_EXT_MIN      = 11'h401;           // Extended lower clamp
  localparam logic signed [11:0] EXT_OFFSET = 12'sh200;          // 64 degrees in 1/8 steps
  localparam logic signed [11:0] EXT_FLOOR  = -12'sh3ff;         // Lowest extended value

  // Scheduler states
  typedef enum logic [1:0] {SCHED_IDLE, SCHED_CONVERT, SCHED_WAIT} tmc_sched_state_t;

endpackage

//--- src/tmc_sched_if.sv
// Link between the register file and the conversion scheduler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface tmc_sched_if;
  logic [2:0] rate_sel;     // Conversion rate code
  logic       standby;      // Standby mode select
  logic       one_shot;     // One-cycle one-shot trigger
  logic       busy;         // Conversion in progress
  logic       conv_start;   // Pulse: conversion begins
  logic       conv_done;    // Pulse: conversion ended

  modport ctrl  (output rate_sel, standby, one_shot, input busy, conv_start, conv_done);
  modport sched (input rate_sel, standby, one_shot, output busy, conv_start, conv_done);
endinterface

//--- src/tmc_conv_sched.sv
// Conversion scheduler: times conversion cycles and the gaps between them.
// Assumes the controller holds rate and mode steady as register levels.
`timescale 1ns/1ns
module tmc_conv_sched import tmc_pkg::*; #(
  parameter int unsigned CONV_CYC   = CONV_CYCLES,
  parameter int unsigned PERIOD_CYC = PERIOD_BASE_CYC
) (
  // Clock and reset
  input wire logic     mclk_i,
  input wire logic     rst_n_i,
  // Controller link
  tmc_sched_if.sched   sif
);

  tmc_sched_state_t   state;        // Scheduler state
  tmc_sched_state_t   next_state;
  logic [CNT_W-1:0]   cnt;          // Cycles since last start
  logic [CNT_W-1:0]   next_cnt;
  logic               start_p;      // Registered start pulse
  logic               next_start_p;
  logic               done_p;       // Registered done pulse
  logic               next_done_p;
  logic [CNT_W-1:0]   period;       // Cycles between starts

  // Period halves per rate step; reserved codes fall back to the slowest rate
  always_comb begin
    if (sif.rate_sel >= RATE_MIN_CODE) begin
      period = CNT_W'(PERIOD_CYC) >> (sif.rate_sel - RATE_MIN_CODE); // RULE_02
    end else begin
      period = CNT_W'(PERIOD_CYC);
    end
  end

  // Next state of the scheduler
  always_comb begin
    next_state   = state;
    next_cnt     = cnt + 1'b1;
    next_start_p = 1'b0;
    next_done_p  = 1'b0;
    case (state)
      SCHED_IDLE: begin
        next_cnt = '0;
        // Run mode starts at once; standby waits for a one-shot
        if (!sif.standby || sif.one_shot) begin // RULE_05 RULE_08
          next_state   = SCHED_CONVERT;
          next_start_p = 1'b1;
        end
      end
      SCHED_CONVERT: begin
        // Fixed-length cycle across all three zones
        if (cnt == CNT_W'(CONV_CYC - 1)) begin // RULE_03
          next_done_p = 1'b1;
          // Standby after the cycle powers down again
          next_state  = sif.standby ? SCHED_IDLE : SCHED_WAIT; // RULE_09
        end
      end
      SCHED_WAIT: begin
        if (sif.standby) begin
          next_state = SCHED_IDLE; // RULE_06
        end else if (cnt >= period - 1'b1) begin
          // Restart at the programmed interval
          next_state   = SCHED_CONVERT; // RULE_05
          next_cnt     = '0;
          next_start_p = 1'b1;
        end
      end
      default: next_state = SCHED_IDLE;
    endcase
  end

  // Scheduler registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= SCHED_IDLE;
      cnt     <= '0;
      start_p <= 1'b0;
      done_p  <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      start_p <= next_start_p;
      done_p  <= next_done_p;
    end
  end

  assign sif.busy       = (state == SCHED_CONVERT); // RULE_12
  assign sif.conv_start = start_p;
  assign sif.conv_done  = done_p;

  // Helper: busy cycles already completed; equals the full length on the done cycle
  logic [CNT_W-1:0] busy_len;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_len <= '0;
    end else if (sif.conv_start) begin
      busy_len <= CNT_W'(1);
    end else if (sif.busy) begin
      busy_len <= busy_len + 1'b1;
    end
  end

  sequence s_trigger;
    sif.standby && sif.one_shot && (state == SCHED_IDLE);
  endsequence

  a_one_shot_run: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_08
    s_trigger |=> sif.conv_start ##1 sif.busy)
    else $error("one-shot did not start a conversion");
  a_standby_no_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_06
    sif.conv_start && $past(sif.standby) |-> $past(sif.one_shot))
    else $error("conversion started in standby without trigger");
  a_conv_length: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_03
    sif.conv_done |-> (busy_len == CNT_W'(CONV_CYC)) && !sif.busy)
    else $error("conversion length wrong");
  a_back_standby: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_09
    sif.conv_done && $past(sif.standby) |-> state == SCHED_IDLE)
    else $error("did not return to standby after conversion");

endmodule // tmc_conv_sched

//--- testbench/tmc_host.sv
// Host model for the register port: one-cycle byte write and read strobes.
// Assumes the block loads read data on the edge that takes the read strobe.
`timescale 1ns/1ns
module tmc_host (
  // Clock
  input  wire logic       mclk_i,
  // Register port toward the block
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  // Idle port at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // Write: held across the taking edge, then data inverted so nothing leans on it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge mclk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask

  // Read: data is taken once the strobe edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge mclk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule // tmc_host

//--- testbench/temp_monitor_conversion_control_bench.sv
// Bench for the conversion control: register table, one-shot, rates, reset.
// Assumes short counts: 20-cycle conversions and a 400-cycle base period.
`timescale 1ns/1ns
module temp_monitor_conversion_control_bench import tmc_pkg::*;;
  // Row: op 0 read and compare, 1 write, 2 wait d cycles
  typedef struct packed {logic [1:0] op; logic [7:0] a; logic [7:0] d; logic [7:0] e;} tmc_row_t;
  logic              mclk_i;           // System clock
  logic              rst_n_i;          // Async reset
  logic              wr, rd;           // Host strobes
  logic [7:0]        addr, wdata, rdata, v;
  logic              meas_enable_o, conv_start_o, standby_o;
  logic [IDEAL_W-1:0] ic1, ic2;        // Ideality codes
  int                cyc, t0, gap, nst, n0, compares, miscompares;
  tmc_row_t          rows [24];

  tmc_host host (.mclk_i(mclk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  tmc_ctrl #(.CONV_CYC(20), .PERIOD_CYC(400)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .int_temp_i(11'h0c8),
    .rem1_temp_i(11'h2a5), .rem2_temp_i(11'h400), .meas_enable_o(meas_enable_o),
    .conv_start_o(conv_start_o), .standby_o(standby_o), .ideal_code1_o(ic1), .ideal_code2_o(ic2));

  // 125 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // Start-to-start spacing; a hang ends the run as a mismatch
  always @(posedge mclk_i) begin
    cyc++;
    if (conv_start_o === 1'b1) begin
      gap = cyc - t0;
      t0 = cyc;
      nst++;
    end
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    rows = '{'{0,8'h03,0,8'h47}, '{0,8'h27,0,8'h12}, '{0,8'h28,0,8'h12}, '{0,8'h02,0,0},
      '{0,8'h55,0,0}, '{1,8'h03,0,0}, '{0,8'h03,0,8'h47}, '{1,8'h02,8'hff,0}, '{0,8'h02,0,0},
      '{1,8'h28,8'h3a,0}, '{0,8'h28,0,8'h3a}, '{1,8'h27,8'hc5,0},
      '{1,8'h0f,8'h9c,0}, '{2,0,3,0}, '{0,8'h02,0,8'h80}, '{1,8'h0f,0,0}, '{2,0,40,0},
      '{0,8'h00,0,8'h19}, '{0,8'h01,0,8'h54}, '{0,8'h10,0,8'ha0}, '{0,8'hfa,0,8'h14},
      '{0,8'hfb,0,8'ha0}, '{0,8'hfc,0,8'h80}, '{0,8'h03,0,8'h47}};
    rst_n_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    chk({meas_enable_o, standby_o, ic1, ic2}, {1'b0, 1'b1, 6'h12, 6'h12});
    #1;
    rst_n_i = 1'b1;
    // Register table, then a one-shot in standby with a refused retrigger
    foreach (rows[i]) begin
      if (rows[i].op == 2'd0) begin
        host.rd(rows[i].a, v);
        chk(v, rows[i].e);
      end else if (rows[i].op == 2'd1)
        host.wr(rows[i].a, rows[i].d);
      else
        repeat (rows[i].d) @(posedge mclk_i);
    end
    chk(nst, 1);
    host.rd(8'h02, v);
    chk(v, 8'h02);
    chk({ic1, ic2, standby_o}, {6'h05, 6'h3a, 1'b1});
    // Standby stays quiet
    n0 = nst;
    repeat (500) @(posedge mclk_i);
    chk({nst, meas_enable_o}, {n0, 1'b0});
    // Every legal rate code, measured after the change settles
    for (int c = 3; c < 8; c++) begin
      host.wr(8'h09, c);
      n0 = nst;
      while (nst < n0 + 3) @(posedge mclk_i);
      chk(gap, 400 >> (c - 3));
      #1;
      chk(meas_enable_o, 1'b1);
    end
    host.rd(8'h03, v);
    chk({v, standby_o}, {8'h07, 1'b0});
    // Standby mid-run finishes then stops
    host.wr(8'h09, 8'h47);
    repeat (30) @(posedge mclk_i);
    n0 = nst;
    repeat (300) @(posedge mclk_i);
    chk({nst, meas_enable_o, standby_o}, {n0, 2'b01});
    // Reset in mid-run
    host.wr(8'h09, 8'h07);
    repeat (10) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b0;
    #2;
    chk({meas_enable_o, standby_o}, 2'b01);
    @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    host.rd(8'h03, v);
    chk(v, 8'h47);
    conclude();
  end
endmodule // temp_monitor_conversion_control_bench
